// ### udt_pkg.sv
// Package for the three-channel up/down timer with capture.
// Assumes a single bus clock; counter clock sources arrive as synchronous tick strobes.
package udt_pkg;

    // Register offsets inside one timer slot
    localparam logic [7:0] UDT_OFF_RELOAD = 8'h00;
    localparam logic [7:0] UDT_OFF_COUNT = 8'h04;
    localparam logic [7:0] UDT_OFF_CONTROL = 8'h08;
    localparam logic [7:0] UDT_OFF_CLEAR = 8'h0c;
    localparam logic [7:0] UDT_OFF_CAPTURE = 8'h10;
    localparam logic [7:0] UDT_OFF_STATUS = 8'h1c;

    // Timer slot select sits above the offset byte
    localparam int UDT_SLOT_LSB = 8;
    localparam int UDT_SLOT_MSB = 9;

    // Reset values and full-scale count
    localparam logic [15:0] UDT_CONTROL_RST = 16'h000a;
    localparam logic [15:0] UDT_RELOAD_RST = 16'h0000;
    localparam logic [15:0] UDT_FULL_SCALE = 16'hffff;

    // Control field positions
    localparam int UDT_CON_PRE_LSB = 0;
    localparam int UDT_CON_PRE_MSB = 1;
    localparam int UDT_CON_DIR_UP = 2;
    localparam int UDT_CON_PERIODIC = 3;
    localparam int UDT_CON_ENABLE = 4;
    localparam int UDT_CON_SRC_LSB = 5;
    localparam int UDT_CON_SRC_MSB = 6;
    localparam int UDT_CON_RELOAD_ON_CLR = 7;
    localparam int UDT_CON_EVT_LSB = 8;
    localparam int UDT_CON_EVT_MSB = 11;
    localparam logic [15:0] UDT_CON_MASK = 16'h0fff;

    // Status and clear bit positions
    localparam int UDT_STA_TIMEOUT = 0;
    localparam int UDT_STA_CAPTURE = 1;
    localparam int UDT_STA_CON_BUSY = 6;
    localparam int UDT_STA_CLR_BUSY = 7;

    // Busy window length in source clock ticks
    localparam logic [1:0] UDT_SYNC_TICKS = 2'd2;

    // Clock source codes
    typedef enum logic [1:0] {
        UDT_SRC_PERIPH,
        UDT_SRC_SYSTEM,
        UDT_SRC_LOWFREQ,
        UDT_SRC_FAST16M
    } udt_src_t;

    // Prescale codes; code 0 means /4 for the two bus clocks, /1 for the oscillators
    localparam logic [1:0] UDT_PRE_SMALL = 2'd0;
    localparam logic [1:0] UDT_PRE_16 = 2'd1;
    localparam logic [1:0] UDT_PRE_256 = 2'd2;
    localparam logic [1:0] UDT_PRE_32768 = 2'd3;

    // Terminal counts (divide factor minus one)
    localparam logic [14:0] UDT_DIV1_LAST = 15'd0;
    localparam logic [14:0] UDT_DIV4_LAST = 15'd3;
    localparam logic [14:0] UDT_DIV16_LAST = 15'd15;
    localparam logic [14:0] UDT_DIV256_LAST = 15'd255;
    localparam logic [14:0] UDT_DIV32768_LAST = 15'd32767;

endpackage

// ### udt_prescaler.sv
// Clock source select and prescaler for one timer channel.
// Assumes source ticks are one-cycle strobes synchronous to ref_clk.
`timescale 1ns/1ps
module udt_prescaler
    import udt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Source ticks
    input wire logic periphTick,
    input wire logic systemTick,
    input wire logic lowFreqTick,
    input wire logic fastTick,
    // Configuration
    input wire logic [1:0] srcSel,
    input wire logic [1:0] preSel,
    input wire logic run,
    // Outputs
    output logic srcTick,
    output logic countTick
);

    logic [14:0] divCnt_q; // Prescale counter
    logic [14:0] divCnt_d;
    logic [14:0] lastCnt; // Terminal count for current setting

    // Terminal count: /4 only for the bus clocks, /1 only for the oscillators
    function automatic logic [14:0] pre_last(input logic [1:0] src, input logic [1:0] pre);
        logic [14:0] r;
        r = UDT_DIV1_LAST;
        unique case (pre)
            UDT_PRE_SMALL: r = (src == UDT_SRC_PERIPH || src == UDT_SRC_SYSTEM) ? UDT_DIV4_LAST : UDT_DIV1_LAST;
            UDT_PRE_16: r = UDT_DIV16_LAST;
            UDT_PRE_256: r = UDT_DIV256_LAST;
            UDT_PRE_32768: r = UDT_DIV32768_LAST;
        endcase
        return r;
    endfunction

    // Source multiplexer
    always_comb begin
        unique case (udt_src_t'(srcSel))
            UDT_SRC_PERIPH: srcTick = periphTick;
            UDT_SRC_SYSTEM: srcTick = systemTick;
            UDT_SRC_LOWFREQ: srcTick = lowFreqTick;
            UDT_SRC_FAST16M: srcTick = fastTick;
        endcase
    end

    // Divider next state; held at zero while stopped so each run starts clean
    always_comb begin
        lastCnt = pre_last(srcSel, preSel);
        divCnt_d = divCnt_q;
        countTick = 1'b0;
        if (!run) begin
            divCnt_d = '0;
        end else if (srcTick) begin
            if (divCnt_q >= lastCnt) begin
                divCnt_d = '0;
                countTick = 1'b1;
            end else begin
                divCnt_d = divCnt_q + 15'd1;
            end
        end
    end

    // Divider register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_q <= '0;
        end else begin
            divCnt_q <= divCnt_d;
        end
    end

endmodule

// ### udt_timers.sv
// Three identical 16-bit up/down timers with reload and event capture.
// Assumes a plain register port with one-cycle strobes and read data one cycle later.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Operation
// - Three identical 16-bit up/down counters
// - Pick peripheral, system, low-freq or 16M clock
// - Prescale 1,4,16,256,32768 with source limits
// - Free-running wraps across the full range
// - Periodic starts at reload value, reloads; enabling does not load the count, a bit 7 clear write does
// - Full scale is 0xFFFF
// - Endpoint raises timeout, sets status bit 0
// - Writing one to clear bit 0 clears timeout
// - Control bit 4 enables, bit 3 periodic
// - Control bit 2 picks count direction
// - Periodic mode reloads on every timeout
// - Bit 7: clear-register write also reloads
// - Count value readable at any time
// - First event assertion captures count, keeps running
// - Sixteen selectable capture event sources
// - Period equals span times prescale factor
// - Capture pending bit 1 blocks until cleared
// - Event select in control bits 11:8
// - Busy status shown for two source ticks
module udt_timers
    import udt_pkg::*;
#(
    parameter int NUM_TIMERS = 3,
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    // Counter clock source ticks
    input wire logic periphTick,
    input wire logic systemTick,
    input wire logic lowFreqTick,
    input wire logic crystalTick,
    input wire logic fastOscTick,
    input wire logic fastSrcIsCrystal,
    // Capture event sources, one group per timer
    input wire logic [NUM_TIMERS-1:0][15:0] captureEvent,
    // Timeout interrupts
    output logic [NUM_TIMERS-1:0] timeoutIrq
);

    // Register state per timer
    logic [NUM_TIMERS-1:0][15:0] reload_q, reload_d; // Reload value
    logic [NUM_TIMERS-1:0][15:0] control_q, control_d; // Control
    logic [NUM_TIMERS-1:0][15:0] count_q, count_d; // Live counter
    logic [NUM_TIMERS-1:0][15:0] capture_q, capture_d; // Captured count
    logic [NUM_TIMERS-1:0] timeout_q, timeout_d; // Sticky timeout flag
    logic [NUM_TIMERS-1:0] capPend_q, capPend_d; // Capture pending
    logic [NUM_TIMERS-1:0] evtPrev_q, evtPrev_d; // Last selected event level
    logic [NUM_TIMERS-1:0][1:0] conBusy_q, conBusy_d; // Control write busy window
    logic [NUM_TIMERS-1:0][1:0] clrBusy_q, clrBusy_d; // Clear write busy window
    logic [15:0] rdData_q, rdData_d; // Read data register

    // Decode helpers
    logic fastTick; // Chosen 16 MHz source
    logic [NUM_TIMERS-1:0] srcTick; // Selected source tick per timer
    logic [NUM_TIMERS-1:0] countTick; // Prescaled tick per timer
    logic [7:0] offset; // Offset inside slot
    logic [1:0] slot; // Timer slot

    assign offset = regAddr[7:0];
    assign slot = regAddr[UDT_SLOT_MSB:UDT_SLOT_LSB];

    // Global configuration picks crystal or internal oscillator as the fast source
    assign fastTick = fastSrcIsCrystal ? crystalTick : fastOscTick;

    // Write hit on a given timer slot and offset
    function automatic logic hit(input logic strobe, input logic [1:0] s, input int idx,
                                 input logic [7:0] off, input logic [7:0] want);
        return strobe && (s == idx[1:0]) && (off == want);
    endfunction

    // Status word assembly, shared by read path
    function automatic logic [15:0] status_word(input logic to, input logic cp,
                                                input logic [1:0] cb, input logic [1:0] kb);
        logic [15:0] w;
        w = 16'h0000;
        w[UDT_STA_TIMEOUT] = to;
        w[UDT_STA_CAPTURE] = cp;
        w[UDT_STA_CON_BUSY] = (cb != 2'd0);
        w[UDT_STA_CLR_BUSY] = (kb != 2'd0);
        return w;
    endfunction

    // One clock select and prescaler per timer
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_pre
            udt_prescaler u_pre (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .periphTick(periphTick),
                .systemTick(systemTick),
                .lowFreqTick(lowFreqTick),
                .fastTick(fastTick),
                .srcSel(control_q[gi][UDT_CON_SRC_MSB:UDT_CON_SRC_LSB]),
                .preSel(control_q[gi][UDT_CON_PRE_MSB:UDT_CON_PRE_LSB]),
                .run(control_q[gi][UDT_CON_ENABLE]),
                .srcTick(srcTick[gi]),
                .countTick(countTick[gi])
            );
        end
    endgenerate

    // Timer next state: configuration, counting, timeout, capture and busy windows
    always_comb begin
        logic up; // Counting direction
        logic periodic; // Reload mode
        logic atEnd; // Counter at its endpoint
        logic clrWr; // Clear register written
        logic evtNow; // Selected event level
        logic [15:0] startVal; // Restart value
        up = 1'b0;
        periodic = 1'b0;
        atEnd = 1'b0;
        clrWr = 1'b0;
        evtNow = 1'b0;
        startVal = 16'h0000;
        reload_d = reload_q;
        control_d = control_q;
        count_d = count_q;
        capture_d = capture_q;
        timeout_d = timeout_q;
        capPend_d = capPend_q;
        evtPrev_d = evtPrev_q;
        conBusy_d = conBusy_q;
        clrBusy_d = clrBusy_q;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            up = control_q[i][UDT_CON_DIR_UP];
            periodic = control_q[i][UDT_CON_PERIODIC];
            atEnd = up ? (count_q[i] == UDT_FULL_SCALE) : (count_q[i] == 16'h0000);
            clrWr = hit(regWrite, slot, i, offset, UDT_OFF_CLEAR);

            // Restart point: reload value in periodic mode, opposite end otherwise
            if (periodic) begin
                startVal = reload_q[i];
            end else begin
                startVal = up ? 16'h0000 : UDT_FULL_SCALE;
            end

            // Register writes; software keeps the timer stopped while reconfiguring
            if (hit(regWrite, slot, i, offset, UDT_OFF_RELOAD)) begin
                reload_d[i] = regWrData;
            end
            if (hit(regWrite, slot, i, offset, UDT_OFF_CONTROL)) begin
                control_d[i] = regWrData & UDT_CON_MASK;
                conBusy_d[i] = UDT_SYNC_TICKS;
            end else if (srcTick[i] && conBusy_q[i] != 2'd0) begin
                conBusy_d[i] = conBusy_q[i] - 2'd1;
            end
            if (clrWr) begin
                clrBusy_d[i] = UDT_SYNC_TICKS;
            end else if (srcTick[i] && clrBusy_q[i] != 2'd0) begin
                clrBusy_d[i] = clrBusy_q[i] - 2'd1;
            end

            // Clears first, so a timeout in the same cycle wins below; capture still sees the old pending bit
            if (clrWr && regWrData[UDT_STA_TIMEOUT]) begin
                timeout_d[i] = 1'b0;
            end
            if (clrWr && regWrData[UDT_STA_CAPTURE]) begin
                capPend_d[i] = 1'b0;
            end

            // Counting on the prescaled tick while enabled
            if (control_q[i][UDT_CON_ENABLE] && countTick[i]) begin
                if (atEnd) begin
                    count_d[i] = startVal;
                    timeout_d[i] = 1'b1;
                end else if (up) begin
                    count_d[i] = count_q[i] + 16'h0001;
                end else begin
                    count_d[i] = count_q[i] - 16'h0001;
                end
            end

            // Clear write while control bit 7 is set reloads at once, in either mode
            if (clrWr && control_q[i][UDT_CON_RELOAD_ON_CLR]) begin
                count_d[i] = reload_q[i];
            end

            // Capture on the rising edge of the selected event, only when not pending
            evtNow = captureEvent[i][control_q[i][UDT_CON_EVT_MSB:UDT_CON_EVT_LSB]];
            evtPrev_d[i] = evtNow;
            if (evtNow && !evtPrev_q[i] && !capPend_q[i]) begin
                capture_d[i] = count_q[i];
                capPend_d[i] = 1'b1;
            end
        end
    end

    // Timer state registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                reload_q[i] <= UDT_RELOAD_RST;
                control_q[i] <= UDT_CONTROL_RST;
                count_q[i] <= 16'h0000;
                capture_q[i] <= 16'h0000;
                conBusy_q[i] <= 2'd0;
                clrBusy_q[i] <= 2'd0;
            end
            timeout_q <= '0;
            capPend_q <= '0;
            evtPrev_q <= '0;
        end else begin
            reload_q <= reload_d;
            control_q <= control_d;
            count_q <= count_d;
            capture_q <= capture_d;
            timeout_q <= timeout_d;
            capPend_q <= capPend_d;
            evtPrev_q <= evtPrev_d;
            conBusy_q <= conBusy_d;
            clrBusy_q <= clrBusy_d;
        end
    end

    // Read mux; unmapped slots, offsets and the write-only clear register read zero
    always_comb begin
        rdData_d = rdData_q;
        if (regRead) begin
            rdData_d = 16'h0000;
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (slot == i[1:0]) begin
                    unique case (offset)
                        UDT_OFF_RELOAD: rdData_d = reload_q[i];
                        UDT_OFF_COUNT: rdData_d = count_q[i];
                        UDT_OFF_CONTROL: rdData_d = control_q[i];
                        UDT_OFF_CAPTURE: rdData_d = capture_q[i];
                        UDT_OFF_STATUS: rdData_d = status_word(timeout_q[i], capPend_q[i],
                                                               conBusy_q[i], clrBusy_q[i]);
                        default: rdData_d = 16'h0000;
                    endcase
                end
            end
        end
    end

    // Read data register; value holds from the cycle after the strobe until the next read
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_q <= 16'h0000;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;
    // Interrupt is the sticky flag itself, already in the bus clock domain
    assign timeoutIrq = timeout_q;

endmodule

// ### udt_timers_monitor.sv
// Checker for the timer block: register port and timeout levels.
// Sees only top-level ports; bound onto every udt_timers instance.
`timescale 1ns/1ps
module udt_timers_monitor
    import udt_pkg::*;
#(
    parameter int NUM_TIMERS = 3,
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdData,
    // Timeout levels
    input wire logic [NUM_TIMERS-1:0] timeoutIrq
);
    // One domain, so one clock and one disable for all
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Software relies on read data standing until the next read
    chk_rd_hold: assert property (!$past(regRead) |-> $stable(regRdData))
        else $error("read data moved without a read");
    // Slot 3 is not mapped
    chk_slot_none: assert property (regRead && regAddr[9:8] == 2'd3 |=> regRdData == 16'h0000)
        else $error("unmapped slot read not zero");
    // Clear register is write-only
    chk_clear_wo: assert property (regRead && regAddr[7:0] == 8'h0c |=> regRdData == 16'h0000)
        else $error("clear register read not zero");
    // Upper control bits are not implemented
    chk_ctl_rsv: assert property (regRead && regAddr[7:0] == 8'h08 |=> regRdData[15:12] == 4'h0)
        else $error("control upper bits read nonzero");
    // Control write then read returns the written fields
    chk_ctl_back: assert property ((regWrite && regAddr == 10'h008) ##2 (regRead && regAddr == 10'h008)
        |=> regRdData[11:0] == $past(regWrData[11:0], 3))
        else $error("control readback differs");
    // Timeout level only drops after a clear write with bit 0
    chk_irq_fall: assert property ($fell(timeoutIrq[0]) |-> $past(regWrite && regAddr == 10'h00c && regWrData[0]))
        else $error("timeout dropped without clear");
    // Level is held while no clear arrives
    chk_irq_hold: assert property (timeoutIrq[1] && !(regWrite && regAddr == 10'h10c) |=> timeoutIrq[1])
        else $error("timeout level not held");
    // Status bit 0 mirrors the timeout line
    chk_irq_stat: assert property (regRead && regAddr == 10'h01c |=> regRdData[0] == $past(timeoutIrq[0]))
        else $error("status bit0 differs from line");

    // Main scenarios reached
    cov_irq0: cover property ($rose(timeoutIrq[0]));
    cov_irq1: cover property ($rose(timeoutIrq[1]));
    cov_cap: cover property (regRead && regAddr == 10'h21c ##1 regRdData[1]);
endmodule

bind udt_timers udt_timers_monitor #(.NUM_TIMERS(NUM_TIMERS), .ADDR_W(ADDR_W)) u_mon (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .timeoutIrq(timeoutIrq));

// ### udt_tick_src.sv
// Model of the clock-source side: one-cycle ticks on a chosen source.
// Assumes ticks are sampled on ref_clk; ticks never come back to back.
`timescale 1ns/1ps
module udt_tick_src (
    // Clock
    input wire logic ref_clk,
    // Ticks, index 0 periph up to 4 fast oscillator
    output logic periphTick,
    output logic systemTick,
    output logic lowFreqTick,
    output logic crystalTick,
    output logic fastOscTick
);
    int seed = 32'h22e6bbaa;
    logic [4:0] tickVec = '0;
    assign {fastOscTick, crystalTick, lowFreqTick, systemTick, periphTick} = tickVec;
    // Random idle gaps: sources run slower than the bus clock
    task burst(input int idx, input int n);
        repeat (n) begin
            repeat ($unsigned($random(seed)) % 3) @(posedge ref_clk);
            @(posedge ref_clk);
            tickVec <= 5'(1 << idx);
            @(posedge ref_clk);
            tickVec <= '0;
        end
    endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the three-channel timer.
// Assumes the checker is bound and the tick model drives the sources.
`timescale 1ns/1ps
module tb_top;
    import udt_pkg::*;
    logic ref_clk = 0, sys_rst = 1, regWrite = 0, regRead = 0, fastSrcIsCrystal = 0;
    logic [9:0] regAddr = '0, a;
    logic [15:0] regWrData = '0, regRdData, rdv, con, d;
    logic [2:0][15:0] captureEvent = '0;
    logic [2:0] timeoutIrq;
    logic pT, sT, lT, cT, fT;
    logic [16:0] e;
    int n_errors = 0, comparisons = 0, seed = 32'h22e6bbaa, dv;
    int offs[7] = '{0, 4, 8, 12, 16, 28, 20};
    // Rows: slot, source, prescale code, up, periodic, crystal, ticks, reload
    int rSl[7] = '{0, 0, 0, 0, 0, 1, 2}, rSr[7] = '{0, 1, 2, 3, 3, 2, 0}, rPr[7] = '{0, 1, 0, 0, 0, 0, 2};
    int rUp[7] = '{0, 0, 0, 1, 0, 1, 0}, rPe[7] = '{0, 0, 0, 0, 0, 1, 0}, rFs[7] = '{0, 0, 0, 1, 0, 0, 0};
    int rN[7] = '{2, 2, 3, 3, 1, 4, 1};
    logic [15:0] rRl[7] = '{16'h0010, 16'h0001, 16'h0003, 16'hfffe, 16'h8000, 16'hfffd, 16'h0002};

    udt_timers u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .periphTick(pT), .systemTick(sT),
        .lowFreqTick(lT), .crystalTick(cT), .fastOscTick(fT), .fastSrcIsCrystal(fastSrcIsCrystal),
        .captureEvent(captureEvent), .timeoutIrq(timeoutIrq));
    udt_tick_src u_src (.ref_clk(ref_clk), .periphTick(pT), .systemTick(sT), .lowFreqTick(lT),
        .crystalTick(cT), .fastOscTick(fT));

    always #50 ref_clk = ~ref_clk;

    // Counter model: n prescaled ticks from the reload value
    function automatic logic [16:0] step(logic [15:0] rl, int up, int per, int n);
        logic [15:0] c;
        logic f;
        c = rl;
        f = 0;
        repeat (n) begin
            if (up ? c == UDT_FULL_SCALE : c == 16'h0000) begin
                c = per ? rl : (up ? 16'h0000 : UDT_FULL_SCALE);
                f = 1;
            end else begin
                c = up ? c + 16'h1 : c - 16'h1;
            end
        end
        return {f, c};
    endfunction

    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task wr(input logic [9:0] ad, input logic [15:0] dt);
        @(posedge ref_clk);
        regAddr <= ad;
        regWrData <= dt;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask

    // Data stands from the cycle after the strobe until the next read
    task rd(input logic [9:0] ad, output logic [15:0] dt);
        @(posedge ref_clk);
        regAddr <= ad;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(negedge ref_clk);
        dt = regRdData;
    endtask

    // Rising edge on timer 2 event source 5
    task ev();
        @(posedge ref_clk);
        captureEvent[2][5] <= 1'b1;
        repeat (2) @(posedge ref_clk);
        captureEvent[2][5] <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    task end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        $display("[FAIL] %0t run too long", $time);
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Reset values, slot 3 and offset 0x14 unmapped
        for (int s = 0; s < 4; s++) begin
            for (int o = 0; o < 7; o++) begin
                rd({2'(s), 8'(offs[o])}, rdv);
                chk(rdv, (s < 3 && offs[o] == 8) ? UDT_CONTROL_RST : 16'h0000);
            end
        end
        chk({13'h0, timeoutIrq}, 16'h0000);
        $display("test 0 done");
        // Random control values, enable kept off
        repeat (4) begin
            d = $random(seed);
            wr(10'h008, d & 16'hffef);
            rd(10'h008, rdv);
            chk(rdv, d & 16'h0fef);
        end
        // Count runs over every source and mode
        for (int i = 0; i < 7; i++) begin
            a = 10'(rSl[i] << 8);
            dv = (rPr[i] == 2) ? 256 : ((rPr[i] == 1) ? 16 : ((rSr[i] < 2) ? 4 : 1));
            con = 16'h0080 | 16'(rSr[i] << 5) | 16'(rPr[i]) | 16'(rUp[i] << 2) | 16'(rPe[i] << 3);
            // Source choice changes on a rising edge like every other input
            @(posedge ref_clk);
            fastSrcIsCrystal <= rFs[i][0];
            wr(a + 10'h008, con);
            wr(a, rRl[i]);
            wr(a + 10'h00c, 16'h0001);
            wr(a + 10'h008, con | 16'h0010);
            u_src.burst(rSr[i] + ((rSr[i] == 3 && rFs[i] == 0) ? 1 : 0), rN[i] * dv);
            repeat (4) @(posedge ref_clk);
            wr(a + 10'h008, con);
            e = step(rRl[i], rUp[i], rPe[i], rN[i]);
            rd(a + 10'h004, rdv);
            chk(rdv, e[15:0]);
            rd(a + 10'h01c, rdv);
            chk(rdv & 16'h0003, {15'h0, e[16]});
            // Disable write just restarted the control window; a single tick leaves the clear window open
            chk(rdv & 16'h00c0, (rN[i] * dv < 2) ? 16'h00c0 : 16'h0040);
            chk({15'h0, timeoutIrq[rSl[i]]}, {15'h0, e[16]});
            $display("test %0d done", i + 1);
        end
        wr(10'h10c, 16'h0001);
        rd(10'h11c, rdv);
        chk(rdv & 16'h0001, 16'h0000);
        chk({15'h0, timeoutIrq[1]}, 16'h0000);
        // Capture holds until its pending bit is cleared
        wr(10'h208, 16'h0580);
        wr(10'h200, 16'h1234);
        wr(10'h20c, 16'h0000);
        ev();
        rd(10'h210, rdv);
        chk(rdv, 16'h1234);
        rd(10'h21c, rdv);
        chk(rdv & 16'h0003, 16'h0002);
        wr(10'h200, 16'h5555);
        wr(10'h20c, 16'h0000);
        ev();
        rd(10'h210, rdv);
        chk(rdv, 16'h1234);
        wr(10'h20c, 16'h0002);
        ev();
        rd(10'h210, rdv);
        chk(rdv, 16'h5555);
        $display("test 8 done");
        end_of_test();
    end
endmodule
